// ### common/ccsc_pkg.sv
// Constants, register map and carrier types for the cascade select host
//
// How it works
// - Host broadcasts device-select write globally, then runs cycles with both selects high.
// - First device full input tied low; last full output low means system full.
// - First device match input tied high; last match output low means system match.
// - Host waits single match delay plus N-1 ripple delays before using results.
// - Host spaces back-to-back next-free writes for the full chain to settle.
package ccsc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_DEV     = 4;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CODE_W      = 12;
  localparam int unsigned CNT_W       = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PS            = 5000;
  localparam int unsigned STROBE_LOW_NS     = 20;
  localparam int unsigned STROBE_HIGH_NS    = 15;
  localparam int unsigned SINGLE_MATCH_NS   = 50;
  localparam int unsigned CHAIN_RIPPLE_NS   = 10;
  localparam int unsigned FULL_RIPPLE_NS    = 6;
  localparam int unsigned SINGLE_FULL_NS    = 30;
  localparam int unsigned SYNC_CYC          = 2;
  localparam int unsigned STROBE_LOW_CYC    = (STROBE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned STROBE_HIGH_CYC   = (STROBE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned MATCH_SETTLE_NS   = SINGLE_MATCH_NS + (NUM_DEV - 1) * CHAIN_RIPPLE_NS;
  localparam int unsigned FULL_SETTLE_NS    = SINGLE_FULL_NS + (NUM_DEV - 1) * FULL_RIPPLE_NS;
  localparam int unsigned MATCH_SETTLE_CYC  =
    (MATCH_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_CYC;
  localparam int unsigned FULL_SETTLE_CYC   =
    (FULL_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_CYC;

  // ----------------------------------------------------------------
  // Register map (APB byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_WDATA  = 8'h04;
  localparam logic [7:0] OFS_RDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Command fields
  localparam int unsigned CMD_CODE_LSB = 0;
  localparam int unsigned CMD_READ_BIT = 12;
  localparam int unsigned CMD_SCOPE_LSB = 16;
  localparam int unsigned CMD_DEV_LSB  = 20;
  localparam int unsigned CMD_KIND_LSB = 24;

  // Status fields
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_MATCH_BIT  = 1;
  localparam int unsigned ST_FULL_BIT   = 2;
  localparam int unsigned ST_MULTI_BIT  = 3;
  localparam int unsigned ST_HIT_BIT    = 4;
  localparam int unsigned ST_SOFT_BIT   = 5;

  // Device-select write and its disable bit
  localparam logic [CODE_W-1:0] CODE_WR_DEVSEL = 12'h008;
  localparam int unsigned       SOFT_DIS_BIT   = 8;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCOPE_GLOBAL,
    SCOPE_LOCAL,
    SCOPE_SOFT,
    SCOPE_NONE
  } ccsc_scope_type;

  typedef enum logic [1:0] {
    KIND_PLAIN,
    KIND_COMPARE,
    KIND_NEXT_FREE,
    KIND_SPARE
  } ccsc_kind_type;

  typedef struct packed {
    logic                 strobe_n;
    logic                 write_n;
    logic [CODE_W-1:0]    code;
    logic                 global_chip_select_n;
    logic [NUM_DEV-1:0]   local_chip_select_n;
  } ccsc_pins_type;

  typedef struct packed {
    logic match_out_n;
    logic full_out_n;
    logic multi_match_n;
    logic any_hit_valid_n;
  } ccsc_flags_type;

endpackage

// ### hw/ccsc_sync.sv
// Two-stage synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module ccsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // One pair of flops per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      logic hold_ff;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_ff <= 1'b1;
          hold_ff <= 1'b1;
        end else begin
          meta_ff <= async_in[i] ^ ~rst_val[i];
          hold_ff <= meta_ff;
        end
      end
      assign sync_out[i] = hold_ff ^ ~rst_val[i];
    end
  endgenerate

endmodule

// ### hw/ccsc_host.sv
// Host controller that runs strobe cycles on a cascade of lookup devices
`timescale 1ns/1ps
module ccsc_host (
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  output ccsc_pkg::ccsc_pins_type              pins,
  output logic      [ccsc_pkg::DATA_W-1:0]     data_lines_out,
  output logic                                 data_lines_oe,
  input  wire logic [ccsc_pkg::DATA_W-1:0]     data_lines_in,
  output logic                                 match_in_n,
  output logic                                 full_in_n,
  input  wire ccsc_pkg::ccsc_flags_type        flags
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_SETTLE,
    ST_SAMPLE
  } ccsc_state_type;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SW = ccsc_pkg::DATA_W + 4;
  logic [SW-1:0] sync_q;
  logic [SW-1:0] sync_rst;
  assign sync_rst = {ccsc_pkg::RST_WORD, 4'hf};

  ccsc_sync #(.W(SW)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({data_lines_in, flags}),
    .rst_val  (sync_rst),
    .sync_out (sync_q)
  );

  ccsc_pkg::ccsc_flags_type flags_s;
  logic [ccsc_pkg::DATA_W-1:0] data_s;
  assign flags_s = sync_q[3:0];
  assign data_s  = sync_q[SW-1:4];

  // Chain ends of this cascade
  assign match_in_n = 1'b1;
  assign full_in_n  = 1'b0;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  ccsc_state_type                   state_ff;
  logic [ccsc_pkg::DATA_W-1:0]      cmd_ff;
  logic [ccsc_pkg::DATA_W-1:0]      wdata_ff;
  logic [ccsc_pkg::DATA_W-1:0]      rdata_ff;
  logic [ccsc_pkg::CNT_W-1:0]       cnt_ff;
  logic                             sys_match_ff;
  logic                             sys_full_ff;
  logic                             multi_ff;
  logic                             hit_ff;
  logic                             soft_on_ff;
  logic                             apb_wr;
  logic                             mapped;
  logic                             start;

  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign mapped  = (paddr == ccsc_pkg::OFS_CMD)   || (paddr == ccsc_pkg::OFS_WDATA) ||
                   (paddr == ccsc_pkg::OFS_RDATA) || (paddr == ccsc_pkg::OFS_STATUS);
  assign pslverr = psel && penable && !mapped;
  assign start   = apb_wr && (paddr == ccsc_pkg::OFS_CMD) && (state_ff == ST_IDLE);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      ccsc_pkg::OFS_CMD: begin
        prdata = cmd_ff;
      end
      ccsc_pkg::OFS_WDATA: begin
        prdata = wdata_ff;
      end
      ccsc_pkg::OFS_RDATA: begin
        prdata = rdata_ff;
      end
      ccsc_pkg::OFS_STATUS: begin
        prdata[ccsc_pkg::ST_BUSY_BIT]  = (state_ff != ST_IDLE);
        prdata[ccsc_pkg::ST_MATCH_BIT] = sys_match_ff;
        prdata[ccsc_pkg::ST_FULL_BIT]  = sys_full_ff;
        prdata[ccsc_pkg::ST_MULTI_BIT] = multi_ff;
        prdata[ccsc_pkg::ST_HIT_BIT]   = hit_ff;
        prdata[ccsc_pkg::ST_SOFT_BIT]  = soft_on_ff;
      end
      default: begin
        prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdata_ff <= ccsc_pkg::RST_WORD;
    end else if (apb_wr && paddr == ccsc_pkg::OFS_WDATA && state_ff == ST_IDLE) begin
      wdata_ff <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ff <= ccsc_pkg::RST_WORD;
    end else if (start) begin
      cmd_ff <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [ccsc_pkg::CODE_W-1:0] code;
  logic                        is_read;
  ccsc_pkg::ccsc_scope_type    scope;
  ccsc_pkg::ccsc_kind_type     kind;
  logic [1:0]                  dev_idx;

  assign code    = cmd_ff[ccsc_pkg::CMD_CODE_LSB +: ccsc_pkg::CODE_W];
  assign is_read = cmd_ff[ccsc_pkg::CMD_READ_BIT];
  assign scope   = ccsc_pkg::ccsc_scope_type'(cmd_ff[ccsc_pkg::CMD_SCOPE_LSB +: 2]);
  assign kind    = ccsc_pkg::ccsc_kind_type'(cmd_ff[ccsc_pkg::CMD_KIND_LSB +: 2]);
  assign dev_idx = cmd_ff[ccsc_pkg::CMD_DEV_LSB +: 2];

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          state_ff <= ST_LOW;
          cnt_ff   <= ccsc_pkg::CNT_W'(ccsc_pkg::STROBE_LOW_CYC - 1);
        end
        ST_LOW: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_HIGH;
            cnt_ff   <= ccsc_pkg::CNT_W'(ccsc_pkg::STROBE_HIGH_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_HIGH: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_SETTLE;
            if (kind == ccsc_pkg::KIND_COMPARE) begin
              cnt_ff <= ccsc_pkg::CNT_W'(ccsc_pkg::MATCH_SETTLE_CYC - 1);
            end else if (kind == ccsc_pkg::KIND_NEXT_FREE) begin
              cnt_ff <= ccsc_pkg::CNT_W'(ccsc_pkg::FULL_SETTLE_CYC - 1);
            end else begin
              cnt_ff <= ccsc_pkg::CNT_W'(ccsc_pkg::SYNC_CYC - 1);
            end
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_SETTLE: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_SAMPLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_SAMPLE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.strobe_n             <= 1'b1;
      pins.write_n              <= 1'b1;
      pins.code                 <= '0;
      pins.global_chip_select_n <= 1'b1;
      pins.local_chip_select_n  <= '1;
      data_lines_out            <= ccsc_pkg::RST_WORD;
      data_lines_oe             <= 1'b0;
    end else if (state_ff == ST_SETUP) begin
      pins.strobe_n             <= 1'b0;
      pins.write_n              <= is_read;
      pins.code                 <= code;
      // Soft scope leaves both selects high
      pins.global_chip_select_n <= (scope != ccsc_pkg::SCOPE_GLOBAL);
      for (int d = 0; d < ccsc_pkg::NUM_DEV; d++) begin
        pins.local_chip_select_n[d] <= !(scope == ccsc_pkg::SCOPE_LOCAL && dev_idx == 2'(d));
      end
      data_lines_out            <= wdata_ff;
      data_lines_oe             <= !is_read;
    end else if (state_ff == ST_LOW && cnt_ff == '0) begin
      pins.strobe_n <= 1'b1;
    end else if (state_ff == ST_SAMPLE) begin
      pins.write_n              <= 1'b1;
      pins.global_chip_select_n <= 1'b1;
      pins.local_chip_select_n  <= '1;
      data_lines_oe             <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= ccsc_pkg::RST_WORD;
    end else if (state_ff == ST_SETTLE && cnt_ff == '0 && is_read) begin
      rdata_ff <= data_s;
    end
  end

  // System flags read in ST_SAMPLE after the settle wait, which is only SYNC_CYC for plain and spare kinds
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_match_ff <= 1'b0;
      sys_full_ff  <= 1'b0;
      multi_ff     <= 1'b0;
      hit_ff       <= 1'b0;
    end else if (state_ff == ST_SAMPLE) begin
      sys_match_ff <= !flags_s.match_out_n;
      sys_full_ff  <= !flags_s.full_out_n;
      multi_ff     <= !flags_s.multi_match_n;
      hit_ff       <= !flags_s.any_hit_valid_n;
    end
  end

  // Tracks whether register selection is armed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_on_ff <= 1'b0;
    end else if (state_ff == ST_SAMPLE && !is_read && code == ccsc_pkg::CODE_WR_DEVSEL &&
                 scope == ccsc_pkg::SCOPE_GLOBAL) begin
      soft_on_ff <= !wdata_ff[ccsc_pkg::SOFT_DIS_BIT];
    end
  end

endmodule

// ### bench/ccsc_host_monitor.sv
// Checker for the cascade host pin levels and cycle spacing
`timescale 1ns/1ps
module ccsc_host_monitor (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire ccsc_pkg::ccsc_pins_type pins,
  input wire logic                    match_in_n,
  input wire logic                    full_in_n
);
  logic [7:0] hi_cnt_ff;
  logic [1:0] kind_ff;
  logic [1:0] run_kind_ff;
  logic [7:0] gap;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hi_cnt_ff <= 8'hff;
    else if (!pins.strobe_n) hi_cnt_ff <= 8'h00;
    else if (hi_cnt_ff != 8'hff) hi_cnt_ff <= hi_cnt_ff + 8'h01;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) kind_ff <= 2'h0;
    else if (psel && penable && pwrite && paddr == ccsc_pkg::OFS_CMD) kind_ff <= pwdata[25:24];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_kind_ff <= 2'h0;
    else if (!pins.strobe_n) run_kind_ff <= kind_ff;
  end
  always_comb begin
    case (run_kind_ff)
      2'h1: gap = 8'(ccsc_pkg::MATCH_SETTLE_CYC + 4);
      2'h2: gap = 8'(ccsc_pkg::FULL_SETTLE_CYC + 4);
      default: gap = 8'h06;
    endcase
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_low_pulse;
    !pins.strobe_n [*4] ##1 pins.strobe_n;
  endsequence
  sequence s_sel_hold;
    $stable({pins.global_chip_select_n, pins.local_chip_select_n, pins.code, pins.write_n}) [*6];
  endsequence
  chk_full_in_tied: assert property (full_in_n == 1'h0)
    else $error("full input of first device not low");
  chk_match_in_tied: assert property (match_in_n == 1'h1)
    else $error("match input of first device not high");
  chk_strobe_width: assert property ($fell(pins.strobe_n) |-> s_low_pulse)
    else $error("strobe low pulse has wrong length");
  chk_sel_held: assert property ($fell(pins.strobe_n) |=> s_sel_hold)
    else $error("selects changed around strobe");
  chk_one_local: assert property ($onehot0(~pins.local_chip_select_n))
    else $error("more than one local select low");
  chk_devsel_global: assert property ($fell(pins.strobe_n) && !pins.write_n &&
    pins.code == ccsc_pkg::CODE_WR_DEVSEL |-> !pins.global_chip_select_n)
    else $error("device select write not broadcast");
  chk_settle_gap: assert property ($fell(pins.strobe_n) |-> hi_cnt_ff >= gap)
    else $error("next strobe before chain settled");
endmodule
bind ccsc_host ccsc_host_monitor i_mon (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pins(pins),
  .match_in_n(match_in_n), .full_in_n(full_in_n));

// ### bench/ccsc_dev_model.sv
// Behavioural chain of cascaded lookup devices
`timescale 1ns/1ps
module ccsc_dev_model #(
  parameter int unsigned DEPTH = 2
) (
  input wire logic                     reset_n,
  input wire ccsc_pkg::ccsc_pins_type  pins,
  input wire logic [31:0]              data_lines_out,
  input wire logic                     data_lines_oe,
  output logic [31:0]                  data_lines_in,
  input wire logic                     match_in_n,
  input wire logic                     full_in_n,
  output ccsc_pkg::ccsc_flags_type     flags
);
  localparam int unsigned N = ccsc_pkg::NUM_DEV;
  localparam logic [11:0] C_NF = 12'h001;
  localparam logic [11:0] C_HPM = 12'h002;
  localparam logic [11:0] C_SR = 12'h007;
  localparam logic [11:0] C_CMP = 12'h019;
  logic [31:0]      mem [N][DEPTH];
  logic [DEPTH-1:0] vld_n [N];
  int unsigned      hits [N];
  logic [3:0]       sel_page [N];
  logic [N-1:0]     dis, sel, drv;
  logic [N:0]       fi_n, mi_n;
  logic             mm, anyhit;
  logic [31:0]      bus, last_q;
  always @(negedge pins.strobe_n) begin
    for (int i = 0; i < N; i++)
      sel[i] = !pins.global_chip_select_n || !pins.local_chip_select_n[i] ||
        (!dis[i] && sel_page[i] == 4'(i));
  end
  // Local results change only at strobe rise and are held between cycles
  always @(posedge pins.strobe_n or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        vld_n[i] = '1;
        hits[i] = 0;
        dis[i] = 1'h1;
        sel_page[i] = 4'h0;
      end
      last_q = 32'h0;
    end else begin
      last_q = data_lines_in;
      for (int i = 0; i < N; i++) begin
        if (sel[i] && !pins.write_n) begin
          if (pins.code == ccsc_pkg::CODE_WR_DEVSEL) begin
            sel_page[i] = data_lines_out[3:0];
            dis[i] = data_lines_out[ccsc_pkg::SOFT_DIS_BIT];
          end else if (pins.code == C_CMP) begin
            hits[i] = 0;
            for (int j = 0; j < DEPTH; j++)
              if (!vld_n[i][j] && mem[i][j] == data_lines_out) hits[i]++;
          end else if (pins.code == C_NF && !fi_n[i] && |vld_n[i]) begin
            for (int j = DEPTH - 1; j >= 0; j--)
              if (vld_n[i][j]) mem[i][j] = data_lines_out;
            for (int j = 0; j < DEPTH; j++)
              if (vld_n[i][j] && mem[i][j] === data_lines_out) begin
                vld_n[i][j] = 1'h0;
                break;
              end
          end
        end
      end
    end
  end
  always_comb begin
    fi_n[0] = full_in_n;
    mi_n[0] = match_in_n;
    mm = 1'h0;
    anyhit = 1'h0;
    for (int i = 0; i < N; i++) begin
      fi_n[i+1] = fi_n[i] | (|vld_n[i]);
      mi_n[i+1] = mi_n[i] & (hits[i] == 0);
      mm = mm | (mi_n[i] && hits[i] > 1) | (!mi_n[i] && hits[i] == 1);
      anyhit = anyhit | (hits[i] > 0);
      drv[i] = sel[i] && pins.write_n && mi_n[i] && hits[i] > 0 &&
        (pins.code == C_HPM || pins.code == C_SR);
    end
    bus = ~last_q;
    for (int i = 0; i < N; i++)
      if (drv[i]) bus = 32'h5a5a_0000 | 32'(i);
    if ($countones(drv) > 1) bus = 'x;
  end
  assign data_lines_in = data_lines_oe ? data_lines_out : bus;
  assign #20 flags = {mi_n[N], fi_n[N], !mm, !anyhit};
endmodule

// ### bench/cam_cascade_select_chain_tb_top.sv
// Self-checking bench for the cascade host
`timescale 1ns/1ps
module cam_cascade_select_chain_tb_top;
  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] wd;
    logic [31:0] st;
    logic [31:0] rd;
  } ccsc_row_type;
  localparam logic [11:0] C_NF = 12'h001;
  localparam logic [11:0] C_HPM = 12'h002;
  localparam logic [11:0] C_SR = 12'h007;
  localparam logic [11:0] C_CMP = 12'h019;
  localparam logic [11:0] C_DEVSEL = ccsc_pkg::CODE_WR_DEVSEL;
  logic                      clk, reset_n, psel, penable, pwrite, pready, pslverr, oe;
  logic                      match_in_n, full_in_n, err_q;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, d_out, d_in, rd_q, st_q;
  ccsc_pkg::ccsc_pins_type   pins;
  ccsc_pkg::ccsc_flags_type  flags;
  ccsc_row_type              rows [12];
  int                        fails, n_tests;
  ccsc_host i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .data_lines_out(d_out), .data_lines_oe(oe),
    .data_lines_in(d_in), .match_in_n(match_in_n), .full_in_n(full_in_n), .flags(flags));
  ccsc_dev_model #(.DEPTH(2)) i_dev (.reset_n(reset_n), .pins(pins), .data_lines_out(d_out),
    .data_lines_oe(oe), .data_lines_in(d_in), .match_in_n(match_in_n),
    .full_in_n(full_in_n), .flags(flags));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] mk(input logic [1:0] kind, input logic [1:0] scope,
    input logic [1:0] dev, input logic rd, input logic [11:0] code);
    return {6'h00, kind, 2'h0, dev, 2'h0, scope, 3'h0, rd, code};
  endfunction
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic run(input logic [31:0] cmd, input logic [31:0] wd);
    int k;
    apb(1'h1, ccsc_pkg::OFS_WDATA, wd);
    apb(1'h1, ccsc_pkg::OFS_CMD, cmd);
    k = 0;
    st_q = 32'h1;
    while (st_q[0] !== 1'h0 && k < 100) begin
      apb(1'h0, ccsc_pkg::OFS_STATUS, 32'h0);
      st_q = rd_q;
      k++;
    end
    chk("busy", {31'h0, st_q[0]}, 32'h0);
    if (cmd[12]) apb(1'h0, ccsc_pkg::OFS_RDATA, 32'h0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    give_verdict();
  end
  initial begin
    reset_n <= 1'h0;
    {psel, penable, pwrite, paddr, pwdata, fails, n_tests} = '0;
    rows = '{
      '{mk(2'h2, 2'h0, 2'h0, 1'h0, C_NF), 32'haa, 32'h00, 32'h0},
      '{mk(2'h2, 2'h0, 2'h0, 1'h0, C_NF), 32'hbb, 32'h00, 32'h0},
      '{mk(2'h2, 2'h0, 2'h0, 1'h0, C_NF), 32'hbb, 32'h00, 32'h0},
      '{mk(2'h1, 2'h0, 2'h0, 1'h0, C_CMP), 32'hbb, 32'h1a, 32'h0},
      '{mk(2'h0, 2'h0, 2'h0, 1'h1, C_HPM), 32'h0, 32'h1a, 32'h5a5a_0000},
      '{mk(2'h0, 2'h0, 2'h0, 1'h0, C_DEVSEL), 32'h000, 32'h3a, 32'h0},
      '{mk(2'h1, 2'h2, 2'h0, 1'h0, C_CMP), 32'haa, 32'h3a, 32'h0},
      '{mk(2'h0, 2'h0, 2'h0, 1'h0, C_DEVSEL), 32'h100, 32'h1a, 32'h0},
      '{mk(2'h1, 2'h2, 2'h0, 1'h0, C_CMP), 32'hdd, 32'h1a, 32'h0},
      '{mk(2'h1, 2'h0, 2'h0, 1'h0, C_CMP), 32'hdd, 32'h00, 32'h0},
      '{mk(2'h1, 2'h1, 2'h1, 1'h0, C_CMP), 32'hbb, 32'h12, 32'h0},
      '{mk(2'h0, 2'h1, 2'h1, 1'h1, C_SR), 32'h0, 32'h12, 32'h5a5a_0001}};
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, ccsc_pkg::OFS_STATUS, 32'h0);
    chk("status after reset", rd_q, ccsc_pkg::RST_WORD);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped error", {31'h0, err_q}, 32'h1);
    apb(1'h1, ccsc_pkg::OFS_RDATA, 32'hffff_ffff);
    apb(1'h0, ccsc_pkg::OFS_RDATA, 32'h0);
    chk("read only data", rd_q, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      run(rows[i].cmd, rows[i].wd);
      chk("status flags", st_q & 32'h3f, rows[i].st);
      if (rows[i].cmd[12]) chk("read data", rd_q, rows[i].rd);
      $display("row %0d done", i);
    end
    for (int i = 0; i < 5; i++) begin
      run(mk(2'h2, 2'h0, 2'h0, 1'h0, C_NF), 32'he0 + 32'(i));
      chk("system full", {31'h0, st_q[2]}, {31'h0, i == 4});
    end
    run(mk(2'h2, 2'h0, 2'h0, 1'h0, C_NF), 32'hff);
    run(mk(2'h1, 2'h0, 2'h0, 1'h0, C_CMP), 32'hff);
    chk("match after write to full system", {31'h0, st_q[1]}, 32'h0);
    chk("full held after compare", {31'h0, st_q[2]}, 32'h1);
    $display("full test done");
    run(mk(2'h1, 2'h3, 2'h0, 1'h0, C_CMP), 32'he0);
    chk("unselected compare", {31'h0, st_q[1]}, 32'h0);
    $display("no select test done");
    give_verdict();
  end
endmodule
